//--- spi_error_check.sv
// Functional notes
// - Flag writes during fuse copy or calibration.
// - Ignored-write check enabled out of reset.
// - Ignored-write error only via its flag, gated.
// - Count, read, write checks need framing enable.
// - Count SCLK pulses in every transaction.
// - Flag pulse counts not multiple of eight.
// - Short write is aborted, register unchanged.
// - Flag reads of invalid addresses.
// - Flag writes to invalid or read-only addresses.
// - Count, read, write checks reset disabled.
`timescale 1ns/1ns
`default_nettype none
module spi_error_check
   import spi_chk_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Serial pins.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Device status.
   input wire logic select_framing_on,
   input wire logic fuse_copy_busy,
   input wire logic calib_busy,
   // Rest of the register map.
   input wire logic [15:0] map_rd_data,
   output logic map_wr,
   output logic [5:0] map_wr_addr,
   output logic [15:0] map_wr_data,
   // Error state.
   output logic [15:0] error_check_enable,
   output logic [3:0] error_flags
);
   spi_frame_if bus ();

   spi_bit_engine #(.COUNT_W(8)) engine_i (
      .clk(clk),
      .sys_rst(sys_rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .bus(bus.engine)
   );

   // ********************************************************
   // Address decode
   // ********************************************************
   function automatic logic addr_valid(input logic [5:0] a);
      return a <= ADDR_LAST_VALID;
   endfunction : addr_valid

   function automatic logic addr_writable(input logic [5:0] a);
      return addr_valid(a) && a != ADDR_FRAME_LEN;
   endfunction : addr_writable

   // ********************************************************
   // Transaction phase and command capture
   // ********************************************************
   phase_t phase;
   logic is_read;
   logic [5:0] addr;
   logic [15:0] data;
   logic [7:0] frame_len;
   logic [5:0] cmd_addr;
   logic cmd_read;
   logic [15:0] read_word;

   assign cmd_addr = bus.rx_byte[5:0];
   assign cmd_read = bus.rx_byte[CMD_READ_BIT];

   always_comb begin
      if (cmd_addr == ADDR_ERR_FLAGS) begin
         read_word = {12'h000, error_flags};
      end else if (cmd_addr == ADDR_ERR_EN) begin
         read_word = error_check_enable;
      end else if (cmd_addr == ADDR_FRAME_LEN) begin
         read_word = {8'h00, frame_len};
      end else if (addr_valid(cmd_addr)) begin
         read_word = map_rd_data;
      end else begin
         read_word = 16'h0000;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= PH_CMD;
      end else if (bus.frame_end) begin
         phase <= PH_CMD;
      end else if (bus.byte_done) begin
         unique case (phase)
            PH_CMD: phase <= PH_DATA_HI;
            PH_DATA_HI: phase <= PH_DATA_LO;
            PH_DATA_LO: phase <= PH_DONE;
            PH_DONE: phase <= PH_DONE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         is_read <= 1'b0;
         addr <= 6'h00;
         data <= 16'h0000;
      end else if (bus.byte_done) begin
         if (phase == PH_CMD) begin
            is_read <= cmd_read;
            addr <= cmd_addr;
         end else if (phase == PH_DATA_HI) begin
            data[15:8] <= bus.rx_byte;
         end else if (phase == PH_DATA_LO) begin
            data[7:0] <= bus.rx_byte;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus.tx_load <= 1'b0;
         bus.tx_word <= 16'h0000;
         bus.tx_on <= 1'b0;
      end else begin
         bus.tx_load <= bus.byte_done && phase == PH_CMD && cmd_read;
         if (bus.byte_done && phase == PH_CMD) begin
            bus.tx_word <= read_word;
            bus.tx_on <= cmd_read;
         end else if (bus.frame_end) begin
            bus.tx_on <= 1'b0;
         end
      end
   end

   // ********************************************************
   // Frame end and read-command checks and register write
   // ********************************************************
   logic framed;
   logic busy;
   logic write_full;
   logic write_ok;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;

   assign framed = select_framing_on;
   assign busy = fuse_copy_busy | calib_busy;
   assign write_full = bus.frame_end && !is_read && phase == PH_DONE;
   assign write_ok = write_full && !busy && addr_writable(addr);

   always_comb begin
      flag_set = 4'h0;
      flag_set[FLAG_IGNORE_BIT] = write_full && busy && error_check_enable[EN_IGNORE_BIT];
      flag_set[FLAG_CLKCNT_BIT] = bus.frame_end && bus.count[2:0] != 3'h0
                                  && error_check_enable[EN_CLKCNT_BIT] && framed;
      flag_set[FLAG_READ_BIT] = bus.byte_done && phase == PH_CMD && cmd_read && !addr_valid(cmd_addr)
                                && error_check_enable[EN_READ_BIT] && framed;
      flag_set[FLAG_WRITE_BIT] = write_full && !addr_writable(addr)
                                 && error_check_enable[EN_WRITE_BIT] && framed;
   end

   assign flag_clr = (write_ok && addr == ADDR_ERR_FLAGS) ? data[3:0] : 4'h0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         error_flags <= ERR_FLAGS_RESET;
      end else begin
         error_flags <= (error_flags & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         error_check_enable <= ERR_EN_RESET;
      end else if (write_ok && addr == ADDR_ERR_EN) begin
         error_check_enable <= data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_len <= 8'h00;
      end else if (bus.frame_end) begin
         frame_len <= bus.count;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         map_wr <= 1'b0;
         map_wr_addr <= 6'h00;
         map_wr_data <= 16'h0000;
      end else begin
         map_wr <= write_ok && addr < ADDR_ERR_FLAGS;
         if (write_ok) begin
            map_wr_addr <= addr;
            map_wr_data <= data;
         end
      end
   end
endmodule : spi_error_check
`default_nettype wire

//--- spi_chk_pkg.sv
`default_nettype none
package spi_chk_pkg;
   // ********************************************************
   // Frame and address layout
   // ********************************************************
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int CMD_READ_BIT = 6;
   localparam logic [7:0] WORD_PULSES = 8'h18;
   localparam logic [2:0] BYTE_PHASE_LAST = 3'h7;
   localparam logic [5:0] ADDR_ERR_FLAGS = 6'h06;
   localparam logic [5:0] ADDR_ERR_EN = 6'h07;
   localparam logic [5:0] ADDR_FRAME_LEN = 6'h08;
   localparam logic [5:0] ADDR_LAST_VALID = 6'h08;

   // ********************************************************
   // Field positions and reset values
   // ********************************************************
   localparam int EN_IGNORE_BIT = 6;
   localparam int EN_CLKCNT_BIT = 5;
   localparam int EN_READ_BIT = 4;
   localparam int EN_WRITE_BIT = 3;
   localparam int FLAG_IGNORE_BIT = 3;
   localparam int FLAG_CLKCNT_BIT = 2;
   localparam int FLAG_READ_BIT = 1;
   localparam int FLAG_WRITE_BIT = 0;
   localparam logic [15:0] ERR_EN_RESET = 16'h0040;
   localparam logic [3:0] ERR_FLAGS_RESET = 4'h0;

   typedef enum logic [1:0] {PH_CMD, PH_DATA_HI, PH_DATA_LO, PH_DONE} phase_t;
endpackage : spi_chk_pkg
`default_nettype wire

//--- spi_frame_if.sv
`timescale 1ns/1ns
`default_nettype none
interface spi_frame_if;
   logic [7:0] count;
   logic [7:0] rx_byte;
   logic byte_done;
   logic frame_end;
   logic tx_load;
   logic [15:0] tx_word;
   logic tx_on;
   modport engine (output count, output rx_byte, output byte_done, output frame_end,
                   input tx_load, input tx_word, input tx_on);
   modport ctrl (input count, input rx_byte, input byte_done, input frame_end,
                 output tx_load, output tx_word, output tx_on);
endinterface : spi_frame_if
`default_nettype wire

//--- spi_bit_engine.sv
`timescale 1ns/1ns
`default_nettype none
module spi_bit_engine #(
   parameter int COUNT_W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Serial pins.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Frame events.
   spi_frame_if.engine bus
);
   if (COUNT_W != 8) begin : g_bad_count
      $error("spi_bit_engine: COUNT_W must be 8");
   end

   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [1:0] pin_prev;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta <= 3'h3;
         pin_sync <= 3'h3;
         pin_prev <= 2'h3;
      end else begin
         pin_meta <= {sclk, cs_n, mosi};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync[2:1];
      end
   end

   logic active;
   logic rise;
   logic fall;
   logic start;
   assign active = ~pin_sync[1];
   assign rise = active & pin_sync[2] & ~pin_prev[1];
   assign fall = active & ~pin_sync[2] & pin_prev[1];
   assign start = ~pin_sync[1] & pin_prev[0];

   // ********************************************************
   // Pulse counter and receive shifter
   // ********************************************************
   logic [6:0] rx_shift;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus.count <= 8'h00;
      end else if (start) begin
         bus.count <= 8'h00;
      end else if (rise && bus.count != 8'hff) begin
         bus.count <= bus.count + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_shift <= 7'h00;
         bus.rx_byte <= 8'h00;
         bus.byte_done <= 1'b0;
         bus.frame_end <= 1'b0;
      end else begin
         bus.byte_done <= rise && bus.count[2:0] == spi_chk_pkg::BYTE_PHASE_LAST;
         bus.frame_end <= pin_sync[1] & ~pin_prev[0];
         if (rise) begin
            rx_shift <= {rx_shift[5:0], pin_sync[0]};
            if (bus.count[2:0] == spi_chk_pkg::BYTE_PHASE_LAST) begin
               bus.rx_byte <= {rx_shift, pin_sync[0]};
            end
         end
      end
   end

   // ********************************************************
   // Transmit shifter
   // ********************************************************
   logic [15:0] tx_shift;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_shift <= 16'h0000;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= active & bus.tx_on;
         if (bus.tx_load) begin
            tx_shift <= bus.tx_word;
         end else if (fall) begin
            miso <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
         end else if (!active) begin
            miso <= 1'b0;
         end
      end
   end
endmodule : spi_bit_engine
`default_nettype wire

//--- spi_error_check_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module spi_error_check_asserts
   import spi_chk_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Pins and status.
   input wire logic cs_n,
   input wire logic select_framing_on,
   input wire logic fuse_copy_busy,
   input wire logic calib_busy,
   // Outputs watched.
   input wire logic map_wr,
   input wire logic [5:0] map_wr_addr,
   input wire logic [15:0] error_check_enable,
   input wire logic [3:0] error_flags
);
   // ********************************
   // Properties
   // ********************************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_one_shot;
      map_wr ##1 !map_wr;
   endsequence
   property p_write;
      map_wr |-> (map_wr_addr < ADDR_ERR_FLAGS && !$past(fuse_copy_busy || calib_busy)) ##0 s_one_shot;
   endproperty
   a_enable_reset: assert property ($fell(sys_rst) |-> error_check_enable == 16'h0040 && error_flags == 4'h0)
      else $error("enable or flags wrong after reset");
   a_ignore_gated: assert property ($rose(error_flags[FLAG_IGNORE_BIT]) |->
      $past(error_check_enable[EN_IGNORE_BIT]) && $past(fuse_copy_busy || calib_busy))
      else $error("ignored-write flag without cause");
   a_count_gated: assert property ($rose(error_flags[FLAG_CLKCNT_BIT]) |->
      $past(error_check_enable[EN_CLKCNT_BIT] && select_framing_on) && cs_n)
      else $error("pulse count flag without cause");
   a_read_gated: assert property ($rose(error_flags[FLAG_READ_BIT]) |->
      $past(error_check_enable[EN_READ_BIT] && select_framing_on))
      else $error("read flag without enable");
   a_write_gated: assert property ($rose(error_flags[FLAG_WRITE_BIT]) |->
      $past(error_check_enable[EN_WRITE_BIT] && select_framing_on) && cs_n)
      else $error("write flag without enable");
   a_flags_sticky: assert property (|($past(error_flags) & ~error_flags) |-> cs_n)
      else $error("flag dropped inside a frame");
   a_write_legal: assert property (p_write)
      else $error("bad write to the map");
   a_write_framed: assert property ($rose(map_wr) |-> $past(cs_n, 3) && cs_n)
      else $error("write before the frame closed");
endmodule : spi_error_check_asserts
bind spi_error_check spi_error_check_asserts spi_error_check_asserts_inst (
   .clk(clk),
   .sys_rst(sys_rst),
   .cs_n(cs_n),
   .select_framing_on(select_framing_on),
   .fuse_copy_busy(fuse_copy_busy),
   .calib_busy(calib_busy),
   .map_wr(map_wr),
   .map_wr_addr(map_wr_addr),
   .error_check_enable(error_check_enable),
   .error_flags(error_flags)
);
`default_nettype wire

//--- spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   // Clock.
   input wire logic clk,
   // Serial pins.
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   // ********************************
   // Framed transfer
   // ********************************
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   task automatic xfer(input logic [23:0] word, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b0;
         mosi <= word[23 - i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         if (i >= 8) begin
            rd = {rd[14:0], (miso_oe === 1'b1) ? miso : 1'bx};
         end
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (12) @(posedge clk);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- spi_error_check_tb.sv
`timescale 1ns/1ns
`default_nettype none
module spi_error_check_tb
   import spi_chk_pkg::*;
;
   logic clk, sys_rst, sclk, cs_n, mosi, miso, miso_oe, map_wr;
   logic select_framing_on, fuse_copy_busy, calib_busy;
   logic [15:0] map_rd_data, map_wr_data, error_check_enable, rd;
   logic [5:0] map_wr_addr;
   logic [3:0] error_flags;
   int fail_count = 0, samples_checked = 0, cycles = 0, writes = 0;
   spi_error_check spi_error_check_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .select_framing_on(select_framing_on),
      .fuse_copy_busy(fuse_copy_busy),
      .calib_busy(calib_busy),
      .map_rd_data(map_rd_data),
      .map_wr(map_wr),
      .map_wr_addr(map_wr_addr),
      .map_wr_data(map_wr_data),
      .error_check_enable(error_check_enable),
      .error_flags(error_flags)
   );
   spi_host_model spi_host_model_inst (
      .clk(clk),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe)
   );
   // ********************************
   // Scenarios
   // ********************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (map_wr === 1'b1) writes <= writes + 1;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input int n = 24);
      spi_host_model_inst.xfer({2'b00, a, d}, n, rd);
   endtask : wr
   task automatic rdreg(input logic [5:0] a);
      spi_host_model_inst.xfer({2'b01, a, 16'h0000}, 24, rd);
   endtask : rdreg
   task automatic clear_flags;
      wr(ADDR_ERR_FLAGS, 16'h000f);
      chk(16'(error_flags), 16'h0000);
   endtask : clear_flags
   task automatic t_reset;
      chk(error_check_enable, 16'h0040);
      chk(error_check_enable & 16'h0038, 16'h0000);
      chk(16'(error_flags), 16'h0000);
   endtask : t_reset
   task automatic t_good;
      wr(6'h03, 16'ha55a);
      chk({10'h000, map_wr_addr}, 16'h0003);
      chk(map_wr_data, 16'ha55a);
      chk(16'(writes), 16'h0001);
      rdreg(6'h02);
      chk(rd, 16'h3c5a);
      rdreg(ADDR_FRAME_LEN);
      chk(rd, 16'h0018);
      wr(ADDR_ERR_EN, 16'h0078);
      rdreg(ADDR_ERR_EN);
      chk(rd, 16'h0078);
      chk(16'(error_flags), 16'h0000);
   endtask : t_good
   task automatic t_ignore;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wr(ADDR_ERR_EN, 16'h0038);
         @(posedge clk);
         fuse_copy_busy <= (k != 1);
         calib_busy <= (k == 1);
         wr(6'h01, 16'h1234);
         fuse_copy_busy <= 1'b0;
         calib_busy <= 1'b0;
         chk(16'(error_flags), (k == 2) ? 16'h0000 : 16'h0008);
         chk(16'(writes), 16'h0001);
         clear_flags();
      end
      wr(ADDR_ERR_EN, 16'h0078);
   endtask : t_ignore
   task automatic t_count;
      wr(6'h02, 16'hffff, 20);
      chk(16'(error_flags), 16'h0004);
      chk(16'(writes), 16'h0001);
      rdreg(ADDR_ERR_FLAGS);
      chk(rd, 16'h0004);
      chk(16'(error_flags), 16'h0004);
      clear_flags();
      select_framing_on <= 1'b0;
      wr(6'h02, 16'hffff, 20);
      rdreg(6'h20);
      wr(6'h08, 16'h00ff);
      chk(16'(error_flags), 16'h0000);
      select_framing_on <= 1'b1;
   endtask : t_count
   task automatic t_addr;
      rdreg(6'h20);
      chk(rd, 16'h0000);
      chk(16'(error_flags), 16'h0002);
      clear_flags();
      for (int k = 0; k < 2; k++) begin
         wr(k ? 6'h3f : 6'h08, 16'h00ff);
         chk(16'(error_flags), 16'h0001);
         chk(16'(writes), 16'h0001);
         clear_flags();
      end
      wr(ADDR_ERR_EN, 16'h0040);
      rdreg(6'h20);
      wr(6'h3f, 16'h00ff, 20);
      chk(16'(error_flags), 16'h0000);
   endtask : t_addr
   initial begin
      sys_rst = 1'b1;
      select_framing_on = 1'b1;
      fuse_copy_busy = 1'b0;
      calib_busy = 1'b0;
      map_rd_data = 16'h3c5a;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_good();
      t_ignore();
      t_count();
      t_addr();
      conclude();
   end
endmodule : spi_error_check_tb
`default_nettype wire
